/* hw/slh_pkg.sv */
/*
  Package for the status LED and fault history block: timebase figures,
  pattern intervals in ticks, fault codes and state enumerations.
  Assumes a 20 MHz system clock and a 1/16 s common timebase tick.
*/
package slh_pkg;

  // System clock and common timebase
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_US       = 62500;
  localparam int TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;

  // Converts a time in ms to whole ticks, rounding up
  function automatic int ms2tick(input int ms);
    return (ms * 1000 + TICK_US - 1) / TICK_US;
  endfunction

  // Times as printed, in milliseconds
  localparam int PULSE_ON_MS  = 250;
  localparam int PULSE_OFF_MS = 3750;
  localparam int HB_HALF_MS   = 500;
  localparam int BOOT_MS      = 2000;
  localparam int FL_HALF_MS   = 250;
  localparam int GAP1_MS      = 1000;
  localparam int GAP3_MS      = 3000;
  localparam int JSENSE_MS    = 5000;
  localparam int JPEND_MS     = 10000;
  localparam int CLR_MS       = 1000;
  localparam int ACK_MS       = 250;
  localparam int POL_MS       = 300000;

  // Same intervals as tick counts
  localparam logic [6:0]  PULSE_ON_T  = 7'(ms2tick(PULSE_ON_MS));
  localparam logic [6:0]  PULSE_PER_T = 7'(ms2tick(PULSE_ON_MS + PULSE_OFF_MS));
  localparam logic [3:0]  HB_HALF_T   = 4'(ms2tick(HB_HALF_MS));
  localparam logic [5:0]  BOOT_T      = 6'(ms2tick(BOOT_MS));
  localparam logic [5:0]  FL_HALF_T   = 6'(ms2tick(FL_HALF_MS));
  localparam logic [5:0]  GAP1_T      = 6'(ms2tick(GAP1_MS));
  localparam logic [5:0]  GAP3_T      = 6'(ms2tick(GAP3_MS));
  localparam logic [7:0]  JSENSE_T    = 8'(ms2tick(JSENSE_MS));
  localparam logic [7:0]  JPEND_T     = 8'(ms2tick(JPEND_MS));
  localparam logic [7:0]  CLR_T       = 8'(ms2tick(CLR_MS));
  localparam logic [2:0]  ACK_T       = 3'(ms2tick(ACK_MS));
  localparam logic [12:0] POL_T       = 13'(ms2tick(POL_MS));

  // Counts and fault codes, high nibble X, low nibble Y
  localparam logic [2:0] WELD_MAX  = 3'h5;
  localparam int         HIST_N    = 10;
  localparam logic [7:0] CODE_SELF = 8'h35;
  localparam logic [7:0] CODE_POL  = 8'h36;
  localparam logic [7:0] CODE_ROLL = 8'h41;
  localparam logic [7:0] CODE_WELD = 8'h42;

  typedef enum logic [2:0] {J_IDLE, J_SENSE, J_PEND, J_CLEAR, J_REL, J_PLAY} slh_jmp_type;
  typedef enum logic [1:0] {F_ON, F_OFF, F_GAP1, F_GAP3} slh_flash_type;

endpackage

/* hw/slh_tick.sv */
/*
  Common timebase: one-cycle tick every TICK_CYCLES system clocks.
  Assumes sys_clk is free running and rst_n is asynchronous, active low.
*/
`timescale 1ns/1ns
module slh_tick
  import slh_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          tick;
  } slh_tick_state_type;

  slh_tick_state_type s_q;
  slh_tick_state_type s_d;

  // Divider; tick lands on the wrap so the period is exact
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TW'(TICK_CYCLES - 1))
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + TW'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule

/* hw/slh_status.sv */
/*
  Red status LED patterns, green bus activity LED, lockout latches and
  a ten-entry fault history with jumper-driven playback and erase.
  Assumes all inputs except rst_n are synchronous to sys_clk; the fault sources and
  the bus engine live elsewhere and drive the level and pulse inputs.
*/
`timescale 1ns/1ns
module slh_status
  import slh_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       jumper_in,
  input  wire logic       heartbeat_mode,
  input  wire logic       ctrl_failed,
  input  wire logic       self_check_fail,
  input  wire logic       polarity_fault,
  input  wire logic       earth_fault,
  input  wire logic       rollout_open,
  input  wire logic       valve_weld_evt,
  input  wire logic       ext_code_valid,
  input  wire logic [3:0] ext_code_x,
  input  wire logic [3:0] ext_code_y,
  input  wire logic       bus_tx_busy,
  input  wire logic       bus_ack_rx,
  output logic            red_led,
  output logic            green_led,
  output logic            hard_lockout,
  output logic            run_enable
);

  typedef struct packed {
    slh_jmp_type                js;
    logic [7:0]                 jt;
    logic [3:0]                 pidx;
    logic [HIST_N-1:0][7:0]     hist;
    logic [3:0]                 hcnt;
    logic [7:0]                 last_code;
    slh_flash_type              fp;
    logic                       fy;
    logic [3:0]                 fcnt;
    logic [5:0]                 ft;
    logic [7:0]                 fcode;
    logic [6:0]                 pcnt;
    logic [3:0]                 hbc;
    logic                       hb;
    logic                       fast;
    logic [5:0]                 bt;
    logic [1:0]                 pwm;
    logic [2:0]                 gcnt;
    logic [12:0]                polt;
    logic                       pol_lock;
    logic                       roll_lock;
    logic [2:0]                 wcnt;
    logic                       weld_lock;
    logic                       red;
    logic                       green;
    logic                       lock;
    logic                       run;
  } slh_state_type;

  slh_state_type q;
  slh_state_type d;
  logic          tick;
  logic          pol_now;
  logic [7:0]    code;
  logic [7:0]    eng_code;
  logic [3:0]    flash_n;
  logic          eng_led;
  logic          gap_end;

  // Shared timebase so every pattern stays in step
  slh_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  always_comb
  begin
    d        = q;
    gap_end  = 1'b0;
    pol_now  = polarity_fault | earth_fault;

    // Lockout latches; only a power cycle clears them
    if (rollout_open)
      d.roll_lock = 1'b1;
    if (valve_weld_evt && !q.weld_lock)
    begin
      d.wcnt = q.wcnt + 3'h1;
      if (q.wcnt == WELD_MAX - 3'h1)
        d.weld_lock = 1'b1;
    end
    // Polarity fault timer resets whenever the fault clears in time
    if (!pol_now && !q.pol_lock)
      d.polt = '0;
    else if (tick && !q.pol_lock)
    begin
      if (q.polt == POL_T - 13'h1)
        d.pol_lock = 1'b1;
      else
        d.polt = q.polt + 13'h1;
    end

    // Active code, rollout and weld lockouts first
    if (q.roll_lock || rollout_open)
      code = CODE_ROLL;
    else if (q.weld_lock)
      code = CODE_WELD;
    else if (self_check_fail)
      code = CODE_SELF;
    else if (pol_now || q.pol_lock)
      code = CODE_POL;
    else if (ext_code_valid)
      code = {ext_code_x, ext_code_y};
    else
      code = 8'h00;
    d.lock = d.roll_lock | d.weld_lock | d.pol_lock;
    d.run  = (code == 8'h00) && !d.lock && !ctrl_failed;

    // New code goes in at index 0; oldest falls off the end
    if (code != q.last_code)
    begin
      d.last_code = code;
      if (code != 8'h00)
      begin
        d.hist = {q.hist[HIST_N-2:0], code};
        if (q.hcnt < 4'(HIST_N))
          d.hcnt = q.hcnt + 4'h1;
      end
    end

    // Pattern counters; the boot timer and green countdown stop, the others run free
    d.pwm = q.pwm + 2'h1;
    if (tick)
    begin
      d.fast = ~q.fast;
      if (q.pcnt == PULSE_PER_T - 7'h1)
        d.pcnt = '0;
      else
        d.pcnt = q.pcnt + 7'h1;
      if (q.hbc == HB_HALF_T - 4'h1)
      begin
        d.hbc = '0;
        d.hb  = ~q.hb;
      end
      else
        d.hbc = q.hbc + 4'h1;
      if (q.bt < BOOT_T)
        d.bt = q.bt + 6'h1;
      if (q.gcnt != 3'h0)
        d.gcnt = q.gcnt - 3'h1;
    end
    // Acknowledge placed after the countdown so a new one always wins
    if (bus_ack_rx)
      d.gcnt = ACK_T;

    // Flash engine; a changed code waits dark for the next tick, then starts at X,
    // so the first flash is as long as the rest instead of a tick-phase stub
    eng_code = (q.js == J_PLAY) ? q.hist[q.pidx] : code;
    flash_n  = q.fy ? q.fcode[3:0] : q.fcode[7:4];
    if (eng_code != q.fcode)
    begin
      d.fcode = eng_code;
      d.fp    = F_OFF;
      d.fy    = 1'b0;
      d.fcnt  = 4'h0;
      d.ft    = FL_HALF_T - 6'h1;
    end
    else if (tick && q.fcode != 8'h00)
    begin
      d.ft = q.ft + 6'h1;
      unique case (q.fp)
        F_ON:
          if (q.ft == FL_HALF_T - 6'h1)
          begin
            d.ft = '0;
            d.fp = F_OFF;
          end
        F_OFF:
          if (q.ft == FL_HALF_T - 6'h1)
          begin
            d.ft = '0;
            if (q.fcnt == flash_n)
              d.fp = (q.fy || q.fcode[3:0] == 4'h0) ? F_GAP3 : F_GAP1;
            else
            begin
              d.fcnt = q.fcnt + 4'h1;
              d.fp   = F_ON;
            end
          end
        F_GAP1:
          if (q.ft == GAP1_T - 6'h1)
          begin
            d.ft   = '0;
            d.fp   = F_ON;
            d.fy   = 1'b1;
            d.fcnt = 4'h1;
          end
        F_GAP3:
          if (q.ft == GAP3_T - 6'h1)
          begin
            d.ft    = '0;
            d.fp    = F_ON;
            d.fy    = 1'b0;
            d.fcnt  = 4'h1;
            gap_end = 1'b1;
          end
      endcase
    end
    eng_led = (q.fp == F_ON) && (q.fcode != 8'h00);

    // Jumper sequence; the technician decides play or erase by release time
    unique case (q.js)
      J_IDLE:
        if (jumper_in)
        begin
          d.js = J_SENSE;
          d.jt = '0;
        end
      J_SENSE:
        if (!jumper_in)
          d.js = J_IDLE;
        else if (tick)
        begin
          if (q.jt == JSENSE_T - 8'h1)
          begin
            d.js = J_PEND;
            d.jt = '0;
          end
          else
            d.jt = q.jt + 8'h1;
        end
      J_PEND:
        if (!jumper_in)
        begin
          if (q.hcnt == 4'h0)
            d.js = J_IDLE;
          else
          begin
            d.js    = J_PLAY;
            d.pidx  = '0;
            d.fcode = '0;
          end
        end
        else if (tick)
        begin
          if (q.jt == JPEND_T - 8'h1)
          begin
            d.js   = J_CLEAR;
            d.jt   = '0;
            d.hist = '0;
            d.hcnt = '0;
          end
          else
            d.jt = q.jt + 8'h1;
        end
      J_CLEAR:
        if (tick)
        begin
          if (q.jt == CLR_T - 8'h1)
            d.js = J_REL;
          else
            d.jt = q.jt + 8'h1;
        end
      J_REL:
        // Normal indication resumes; wait for removal so it cannot retrigger
        if (!jumper_in)
          d.js = J_IDLE;
      J_PLAY:
        // Advance on the very edge the gap ends, so no stray flash of the old code shows
        if (gap_end)
        begin
          if (q.pidx + 4'h1 == q.hcnt)
            d.js = J_IDLE;
          else
          begin
            d.pidx  = q.pidx + 4'h1;
            d.fcode = '0;
          end
        end
    endcase

    // Red LED source selection
    if (q.js == J_SENSE || q.js == J_CLEAR)
      d.red = 1'b1;
    else if (q.js == J_PEND)
      d.red = 1'b0;
    else if (q.js == J_PLAY)
      d.red = eng_led;
    else if (q.bt < BOOT_T || ctrl_failed)
      d.red = q.fast;
    else if (code != 8'h00)
      d.red = eng_led;
    else if (heartbeat_mode)
      d.red = q.hb | (q.pwm == 2'h0);
    else
      d.red = q.pcnt < PULSE_ON_T;

    // Green LED runs regardless of thermostat type
    d.green = bus_tx_busy ? q.fast : (q.gcnt != 3'h0);
  end

  // Single state register; everything resets to zero at power-up
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign red_led      = q.red;
  assign green_led    = q.green;
  assign hard_lockout = q.lock;
  assign run_enable   = q.run;

  a_sense_red_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.js == J_SENSE) |=> red_led)
    else $error("Red LED not solid while jumper sensed");

  a_pend_red_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.js == J_PEND) |=> !red_led)
    else $error("Red LED not off while playback pending");

  a_clear_wipes_hist: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.js == J_PEND && jumper_in && tick && q.jt == JPEND_T - 8'h1)
    |=> (q.js == J_CLEAR && q.hcnt == 4'h0 && q.hist == '0) ##1 red_led)
    else $error("History not erased on jumper timeout");

  a_play_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.js == J_PEND && !jumper_in && q.hcnt == 4'h0) |=> (q.js == J_IDLE))
    else $error("Empty history did not return to normal");

  a_play_newest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(q.js == J_PLAY) |-> (q.pidx == 4'h0 && q.hcnt != 4'h0))
    else $error("Playback did not start at newest entry");

  a_hist_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.hcnt <= 4'(HIST_N)))
    else $error("History count above ten");

  a_rollout_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rollout_open |=> (hard_lockout && q.fcode == CODE_ROLL))
    else $error("Rollout did not lock out with 4+1");

  a_weld_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (valve_weld_evt && q.wcnt == WELD_MAX - 3'h1 && !q.roll_lock) |=> ##1 (hard_lockout && q.fcode == CODE_WELD))
    else $error("Fifth weld did not lock out with 4+2");

  a_pol_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && pol_now && !q.pol_lock && q.polt == POL_T - 13'h1) |=> hard_lockout)
    else $error("Polarity fault did not lock out after timeout");

  a_green_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!bus_tx_busy && q.gcnt == 3'h0) |=> !green_led)
    else $error("Green LED lit without bus activity");

  a_ack_blink: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_ack_rx && !bus_tx_busy) ##1 !bus_tx_busy |=> green_led)
    else $error("Acknowledge did not blink green LED");

endmodule

/* tb/slh_tech_model.sv */
/*
  Technician model: places and lifts the jumper across the thermostat terminals.
  Assumes the bench calls its tasks; the jumper level changes only on falling edges.
*/
`timescale 1ns/1ns
module slh_tech_model
(
  input  wire logic sys_clk,
  output logic      jumper_in
);
  // No jumper at power-up
  initial jumper_in = 1'b0;

  // Jumper goes on between edges so the design samples a clean level
  task automatic place();
    @(negedge sys_clk);
    jumper_in = 1'b1;
  endtask

  // Holds the jumper, then lifts it; a hold inside the 10 s window asks for
  // playback, a longer one lets the history be erased
  task automatic hold_and_remove(input int cycles);
    repeat (cycles) @(negedge sys_clk);
    jumper_in = 1'b0;
  endtask
endmodule

/* tb/slh_status_test.sv */
/*
  Self-checking bench for the status LED and fault history block.
  Assumes a four-clock tick so that every pattern and timeout runs short.
*/
`timescale 1ns/1ns
module slh_status_test import slh_pkg::*;;
  localparam int unsigned TC = 4;
  localparam int          ENDGAP = (FL_HALF_T + GAP3_T) * TC;
  logic       sys_clk         = 1'b0;
  logic       rst_n           = 1'b0;
  logic       heartbeat_mode  = 1'b0;
  logic       ctrl_failed     = 1'b0;
  logic       self_check_fail = 1'b0;
  logic       polarity_fault  = 1'b0;
  logic       earth_fault     = 1'b0;
  logic       rollout_open    = 1'b0;
  logic       valve_weld_evt  = 1'b0;
  logic       ext_code_valid  = 1'b0;
  logic [3:0] ext_code_x      = 4'h0;
  logic [3:0] ext_code_y      = 4'h0;
  logic       bus_tx_busy     = 1'b0;
  logic       bus_ack_rx      = 1'b0;
  logic       jumper_in;
  logic       red_led;
  logic       green_led;
  logic       hard_lockout;
  logic       run_enable;
  int         miscompares     = 0;
  int         cmp_count       = 0;

  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;

  slh_status #(.TICK_CYCLES(TC)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .jumper_in(jumper_in),
    .heartbeat_mode(heartbeat_mode), .ctrl_failed(ctrl_failed), .self_check_fail(self_check_fail),
    .polarity_fault(polarity_fault), .earth_fault(earth_fault), .rollout_open(rollout_open),
    .valve_weld_evt(valve_weld_evt), .ext_code_valid(ext_code_valid), .ext_code_x(ext_code_x),
    .ext_code_y(ext_code_y), .bus_tx_busy(bus_tx_busy), .bus_ack_rx(bus_ack_rx), .red_led(red_led),
    .green_led(green_led), .hard_lockout(hard_lockout), .run_enable(run_enable));

  slh_tech_model tech_u (.sys_clk(sys_clk), .jumper_in(jumper_in));

  // Counted comparisons; run lengths get a tolerance because tick phase is free
  task automatic cmp(input string what, input int exp, input int got, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol)
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Waits for an LED to reach a level, then counts clocks it stays there
  task automatic run_len(input bit grn, input logic lvl, output int n);
    int w;
    w = 0;
    while ((grn ? green_led : red_led) !== lvl && w < 2000)
    begin
      @(negedge sys_clk);
      w++;
    end
    n = 0;
    while ((grn ? green_led : red_led) === lvl && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Reads one flash group from the red LED; optional sync on a long dark gap
  task automatic flashes(input bit sync, input bit chk_gap, output int x, output int y);
    int n;
    x = 0;
    y = 0;
    n = 0;
    while (sync && n <= ENDGAP - 4 * TC && n < 2000) run_len(0, 1'b0, n);
    for (int i = 0; i < 40; i++)
    begin
      run_len(0, 1'b1, n);
      cmp("flash on time", FL_HALF_T * TC, n, 1);
      if (y > 0 || x < 0) y++; else x++;
      run_len(0, 1'b0, n);
      if (n > ENDGAP - 4 * TC) break;
      if (n > 2 * FL_HALF_T * TC) cmp("pause between parts", (FL_HALF_T + GAP1_T) * TC, n, TC);
      if (n > 2 * FL_HALF_T * TC) x = -x;
    end
    if (x < 0) x = -x;
    if (chk_gap) cmp("closing gap", ENDGAP, n, TC);
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    {heartbeat_mode, ctrl_failed, self_check_fail, polarity_fault, earth_fault} = 5'h00;
    {rollout_open, valve_weld_evt, ext_code_valid, bus_tx_busy, bus_ack_rx} = 5'h00;
    {ext_code_x, ext_code_y} = 8'h00;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask

  // Normal pulse: one short flash then a long dark spell
  task automatic chk_pulse(input string what);
    int n;
    run_len(0, 1'b0, n);
    run_len(0, 1'b1, n);
    cmp({what, " pulse on"}, PULSE_ON_T * TC, n, 1);
    run_len(0, 1'b0, n);
    cmp({what, " pulse off"}, (PULSE_PER_T - PULSE_ON_T) * TC, n, 1);
  endtask

  task automatic t_boot_modes();
    int n;
    int hi;
    do_reset();
    run_len(0, 1'b1, n);
    cmp("boot blink on", TC, n, 1);
    cmp_bit("run enable idle", 1'b1, run_enable);
    repeat (BOOT_T * TC) @(negedge sys_clk);
    chk_pulse("idle");
    heartbeat_mode = 1'b1;
    n = 0;
    for (int i = 0; i < 40 && n <= (PULSE_ON_T + 1) * TC; i++) run_len(0, 1'b1, n);
    cmp("heartbeat bright", HB_HALF_T * TC, n, 1);
    hi = 1;
    repeat (HB_HALF_T * TC - 1)
    begin
      @(negedge sys_clk);
      hi += (red_led === 1'b1);
    end
    cmp("heartbeat dim duty", HB_HALF_T * TC / 4, hi, 3);
    do_reset();
    ctrl_failed = 1'b1;
    repeat (2 * BOOT_T * TC) @(negedge sys_clk);
    run_len(0, 1'b0, n);
    run_len(0, 1'b1, n);
    cmp("failed fast blink", TC, n, 1);
    cmp_bit("run enable failed", 1'b0, run_enable);
  endtask

  // Level faults and an external single code, each shown and then cleared
  task automatic t_codes();
    int x;
    int y;
    logic [7:0] exp_c [3] = '{CODE_SELF, CODE_POL, 8'h20};
    for (int k = 0; k < 3; k++)
    begin
      do_reset();
      self_check_fail = (k == 0);
      earth_fault = (k == 1);
      {ext_code_valid, ext_code_x} = (k == 2) ? 5'h12 : 5'h00;
      flashes(1, 1, x, y);
      cmp("code first part", exp_c[k][7:4], x, 0);
      cmp("code second part", exp_c[k][3:0], y, 0);
      cmp_bit("run enable with code", 1'b0, run_enable);
      {self_check_fail, earth_fault, ext_code_valid} = 3'h0;
      repeat (3) @(negedge sys_clk);
      cmp_bit("run enable after clear", 1'b1, run_enable);
    end
  endtask

  task automatic t_lockouts();
    int x;
    int y;
    do_reset();
    rollout_open = 1'b1;
    @(negedge sys_clk);
    rollout_open = 1'b0;
    cmp_bit("rollout lockout", 1'b1, hard_lockout);
    flashes(1, 1, x, y);
    cmp("rollout code", CODE_ROLL, x * 16 + y, 0);
    cmp_bit("rollout lockout kept", 1'b1, hard_lockout);
    do_reset();
    for (int i = 0; i < WELD_MAX; i++)
    begin
      cmp_bit("no lockout below weld limit", 1'b0, hard_lockout);
      valve_weld_evt = 1'b1;
      @(negedge sys_clk);
      valve_weld_evt = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    cmp_bit("weld lockout", 1'b1, hard_lockout);
    flashes(1, 1, x, y);
    cmp("weld code", CODE_WELD, x * 16 + y, 0);
    // Polarity cleared early resumes; held for the full span locks out
    do_reset();
    polarity_fault = 1'b1;
    repeat ((POL_T - 100) * TC) @(negedge sys_clk);
    cmp_bit("polarity short no lockout", 1'b0, hard_lockout);
    polarity_fault = 1'b0;
    repeat (3) @(negedge sys_clk);
    cmp_bit("polarity cleared resumes", 1'b1, run_enable);
    polarity_fault = 1'b1;
    repeat ((POL_T + 2) * TC) @(negedge sys_clk);
    polarity_fault = 1'b0;
    cmp_bit("polarity held lockout", 1'b1, hard_lockout);
  endtask

  task automatic t_green();
    int n;
    int tg;
    logic prev;
    do_reset();
    cmp_bit("green idle", 1'b0, green_led);
    bus_ack_rx = 1'b1;
    @(negedge sys_clk);
    bus_ack_rx = 1'b0;
    run_len(1, 1'b1, n);
    cmp("green ack blink", ACK_T * TC, n, TC);
    run_len(1, 1'b0, n);
    cmp("green dark after ack", 2000, n, 0);
    bus_tx_busy = 1'b1;
    prev = green_led;
    tg = 0;
    repeat (8 * TC)
    begin
      @(negedge sys_clk);
      tg += (green_led !== prev);
      prev = green_led;
    end
    cmp("green toggles while sending", 8, tg, 1);
    bus_tx_busy = 1'b0;
    repeat (2) @(negedge sys_clk);
    cmp_bit("green off after send", 1'b0, green_led);
  endtask

  // One jumper pass: solid on, dark while pending, then lift or keep on
  task automatic jumper_pass(input bit erase);
    int n;
    tech_u.place();
    repeat (2) @(negedge sys_clk);
    cmp_bit("red solid on jumper", 1'b1, red_led);
    repeat ((JSENSE_T - 2) * TC) @(negedge sys_clk);
    cmp_bit("red solid held", 1'b1, red_led);
    repeat (6 * TC) @(negedge sys_clk);
    cmp_bit("red dark pending", 1'b0, red_led);
    if (!erase) tech_u.hold_and_remove(16 * TC);
    if (!erase) return;
    repeat ((JPEND_T - 12) * TC) @(negedge sys_clk);
    cmp_bit("red dark late pending", 1'b0, red_led);
    run_len(0, 1'b1, n);
    cmp("red solid while erasing", CLR_T * TC, n, TC);
    tech_u.hold_and_remove(8 * TC);
  endtask

  task automatic t_history();
    int x;
    int y;
    do_reset();
    repeat ((BOOT_T + 2) * TC) @(negedge sys_clk);
    jumper_pass(0);
    chk_pulse("empty playback");
    ext_code_valid = 1'b1;
    for (int v = 1; v <= HIST_N + 1; v++)
    begin
      ext_code_x = 4'(v);
      repeat (3) @(negedge sys_clk);
    end
    ext_code_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    jumper_pass(0);
    for (int i = 0; i < HIST_N; i++)
    begin
      flashes(0, i < HIST_N - 1, x, y);
      cmp("playback code", HIST_N + 1 - i, x, 0);
    end
    chk_pulse("after playback");
    // Shifts the erase so its solid spell does not end where a pulse flash starts
    repeat (8 * TC) @(negedge sys_clk);
    jumper_pass(1);
    chk_pulse("after erase");
    jumper_pass(0);
    chk_pulse("playback after erase");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized above the roughly 55k clocks the scenarios need
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    $display("mismatch watchdog expected finish seen hang");
    conclude();
  end

  // Scenario sequence
  initial
  begin
    t_boot_modes();
    t_codes();
    t_lockouts();
    t_green();
    t_history();
    conclude();
  end
endmodule
